// ### hw/dlio_counters.sv
// Delay-line register store with pulse accumulators, shifters, real-time counter and timers.
`timescale 1ns/1ps
`default_nettype none
`include "dlio_map.svh"
module dlio_counters import dlio_pkg::*; #(
    parameter int BIT_NUM = `DLIO_BIT_KHZ,
    parameter int BIT_DEN = `DLIO_PCLK_KHZ,
    parameter int TICKS_100CPS = `DLIO_BIT_HZ / `DLIO_TICK_HZ,
    parameter int TICKS_OUT = `DLIO_BIT_HZ / `DLIO_OUT_HZ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dlio_pulse_t pulse_in,
    input wire logic ground_command_shifter_bit,
    input wire logic ground_command_shifter_strobe,
    input wire logic radar_bit,
    output logic accel_interrogate,
    output logic radar_pulse,
    output dlio_out_t pulse_out,
    output logic cp_interrupt
);
    localparam int NW = `DLIO_WORD_BITS;
    localparam int NREG = `DLIO_REG_COUNT;

    function automatic int acc_idx(input int j);
        return (j < 6) ? j : ((j == 6) ? 8 : ((j == 7) ? 11 : j + 6));
    endfunction

    function automatic logic [25:0] pair_of(input logic [NW-1:0] lo, input logic [NW-1:0] hi);
        return {hi, lo};
    endfunction

    // Bit clock, phase and count-up divider chain.
    logic [15:0] frac;
    logic [3:0] bit_cnt;
    logic [2:0] phase;
    logic [12:0] tick_cnt;
    logic [7:0] out_cnt;
    logic sq_100;
    wire [16:0] frac_sum = {1'b0, frac} + 17'(BIT_NUM);
    wire bit_tick = frac_sum >= 17'(BIT_DEN);
    wire phase_tick = bit_tick && (bit_cnt == 4'(`DLIO_BITS_PER_PHASE - 1));
    wire tick_wrap = bit_tick && (tick_cnt == 13'(TICKS_100CPS / 2 - 1));
    wire out_tick = bit_tick && (out_cnt == 8'(TICKS_OUT - 1));
    wire rt_event = tick_wrap && sq_100;
    wire parity_even = phase >= 3'd3;
    wire phase_bc = (phase != 3'd0) && (phase != 3'd3);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frac <= 16'h0000;
            bit_cnt <= 4'h0;
            phase <= 3'h0;
            tick_cnt <= 13'h0000;
            out_cnt <= 8'h00;
            sq_100 <= 1'b0;
        end else begin
            frac <= bit_tick ? 16'(frac_sum - 17'(BIT_DEN)) : frac_sum[15:0];
            if (bit_tick) begin
                bit_cnt <= phase_tick ? 4'h0 : bit_cnt + 4'h1;
                tick_cnt <= tick_wrap ? 13'h0000 : tick_cnt + 13'h0001;
                out_cnt <= out_tick ? 8'h00 : out_cnt + 8'h01;
            end
            if (tick_wrap) begin
                sq_100 <= ~sq_100;
            end
            if (phase_tick) begin
                phase <= (phase == 3'(`DLIO_PHASES - 1)) ? 3'h0 : phase + 3'h1;
            end
        end
    end

    // Input pulse latches.
    logic [19:0] acc_clear;
    logic [19:0] acc_held;
    logic up_fresh;
    logic up_held;
    logic up_done;

    dlio_pulse_latch #(.WIDTH(20)) u_acc_latch (
        .pclk(pclk),
        .presetn(presetn),
        .pin({pulse_in.plus, pulse_in.minus}),
        .clear(acc_clear),
        .held(acc_held),
        .fresh()
    );

    dlio_pulse_latch #(.WIDTH(1)) u_up_latch (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ground_command_shifter_strobe),
        .clear(up_done),
        .held(up_held),
        .fresh(up_fresh)
    );

    wire [9:0] held_plus = acc_held[19:10];
    wire [9:0] held_minus = acc_held[9:0];

    logic up_s1;
    logic up_s2;
    logic up_val;
    logic rd_s1;
    logic rd_s2;
    logic rng_active;
    logic rng_pend;
    logic rng_val;
    logic rng_done;
    logic rt_pend;
    logic rt_done;
    logic [2:0] out_pend;
    logic [2:0] out_done;
    logic [2:0] irq_flags;
    logic [2:0] irq_set;
    logic [1:0] tmr_zero;
    logic rng_stop;
    dlio_out_t next_pulse;

    // Register bus decode.
    dlio_apb_state_t state;
    logic [NW-1:0] dl [NREG];
    logic [NW-1:0] next_dl [NREG];
    wire [4:0] bus_idx = paddr[6:2];
    wire dl_hit = paddr < `DLIO_OFS_DL_END;
    wire st_hit = paddr == `DLIO_OFS_STATUS;
    wire irq_hit = paddr == `DLIO_OFS_IRQ;
    wire ctrl_hit = paddr == `DLIO_OFS_CTRL;
    wire [2:0] bus_slot = 3'(bus_idx % 5'd6);
    wire [2:0] bus_slot_dl1 = 3'((bus_idx + 5'd4) % 5'd6);
    wire bus_avail = phase_bc && ((phase == bus_slot) || (phase == bus_slot_dl1));
    wire bus_ready = !dl_hit || bus_avail;
    wire bus_err = !(dl_hit || st_hit || irq_hit || ctrl_hit) || (dl_hit && pwrite && bus_idx < 5'(`DLIO_IDX_ACC_CH4));
    wire bus_go = (state == DLIO_IDLE) && psel && penable && bus_ready;
    wire commit = (state == DLIO_ACK) && psel && penable && pwrite && !pslverr;
    wire dl_load = commit && dl_hit;
    wire rng_start = commit && ctrl_hit && pwdata[`DLIO_CTRL_RANGE_REQ];
    wire [2:0] irq_clear = (commit && irq_hit) ? pwdata[2:0] : 3'h0;
    wire [31:0] status_word = {27'h0, rng_active, phase, ~parity_even};
    wire [31:0] bus_rdata = dl_hit ? {19'h0, dl[bus_idx]} : (st_hit ? status_word :
                           (irq_hit ? {29'h0, irq_flags} : {31'h0, rng_active}));

    // One pass of the loop: each phase services one slot in each of the four channels.
    logic [25:0] up_pair;
    logic [25:0] rng_pair;
    logic [25:0] rt_pair;
    logic [NW-1:0] tv;
    always_comb begin
        up_pair = (pair_of(dl[`DLIO_IDX_GROUND_COMMAND_SHIFTER], dl[`DLIO_IDX_GROUND_COMMAND_SHIFTER + 1]) << 1) | {25'h0, up_val};
        rng_pair = (pair_of(dl[`DLIO_IDX_RANGE], dl[`DLIO_IDX_RANGE + 1]) << 1) | {25'h0, rng_val};
        rt_pair = pair_of(dl[`DLIO_IDX_REALTIME], dl[`DLIO_IDX_REALTIME + 1]) + 26'h0000001;
        tv = '0;
        for (int i = 0; i < NREG; i++) begin
            next_dl[i] = dl[i];
        end
        acc_clear = '0;
        up_done = 1'b0;
        rng_done = 1'b0;
        rng_stop = 1'b0;
        rt_done = 1'b0;
        out_done = 3'h0;
        tmr_zero = 2'h0;
        irq_set = 3'h0;
        next_pulse = '0;
        if (phase_tick) begin
            for (int j = 0; j < 10; j++) begin
                if (3'(acc_idx(j) % 6) == phase) begin
                    next_dl[acc_idx(j)] = dl[acc_idx(j)] + NW'(held_plus[j]) - NW'(held_minus[j]);
                    acc_clear[j] = 1'b1;
                    acc_clear[j + 10] = 1'b1;
                end
            end
            // A bit whose strobe edge is still landing waits one loop so that its value has settled.
            if (phase == 3'(`DLIO_IDX_GROUND_COMMAND_SHIFTER % 6) && up_held && !up_fresh) begin
                up_done = 1'b1;
                if (!dl[`DLIO_IDX_GROUND_COMMAND_SHIFTER + 1][`DLIO_MARKER_POS - NW]) begin
                    next_dl[`DLIO_IDX_GROUND_COMMAND_SHIFTER] = up_pair[NW-1:0];
                    next_dl[`DLIO_IDX_GROUND_COMMAND_SHIFTER + 1] = up_pair[25:NW];
                    irq_set[`DLIO_IRQ_GROUND_COMMAND_SHIFTER] = up_pair[`DLIO_MARKER_POS];
                end
            end
            if (phase == 3'(`DLIO_IDX_RANGE % 6) && rng_pend) begin
                rng_done = 1'b1;
                next_dl[`DLIO_IDX_RANGE] = rng_pair[NW-1:0];
                next_dl[`DLIO_IDX_RANGE + 1] = rng_pair[25:NW];
                rng_stop = rng_pair[`DLIO_MARKER_POS];
            end
            if (phase == 3'(`DLIO_IDX_REALTIME % 6) && rt_pend) begin
                rt_done = 1'b1;
                next_dl[`DLIO_IDX_REALTIME] = rt_pair[NW-1:0];
                next_dl[`DLIO_IDX_REALTIME + 1] = rt_pair[25:NW];
            end
            for (int k = 0; k < 2; k++) begin
                if (3'((`DLIO_IDX_TIMER1 + k) % 6) == phase && dl[`DLIO_IDX_TIMER1 + k] != '0) begin
                    tv = dl[`DLIO_IDX_TIMER1 + k] + 13'h0001;
                    next_dl[`DLIO_IDX_TIMER1 + k] = tv;
                    tmr_zero[k] = tv == '0;
                end
            end
            for (int k = 0; k < 3; k++) begin
                if (3'((`DLIO_IDX_OUT0 + k) % 6) == phase && out_pend[k]) begin
                    out_done[k] = 1'b1;
                    if (dl[`DLIO_IDX_OUT0 + k] != '0) begin
                        next_dl[`DLIO_IDX_OUT0 + k] = dl[`DLIO_IDX_OUT0 + k][NW-1] ?
                            dl[`DLIO_IDX_OUT0 + k] + 13'h0001 : dl[`DLIO_IDX_OUT0 + k] - 13'h0001;
                        next_pulse.plus[k] = !dl[`DLIO_IDX_OUT0 + k][NW-1];
                        next_pulse.minus[k] = dl[`DLIO_IDX_OUT0 + k][NW-1];
                    end
                end
            end
        end
        irq_set[`DLIO_IRQ_TIMER1] = tmr_zero[0];
        irq_set[`DLIO_IRQ_TIMER2] = tmr_zero[1];
        if (irq_clear[`DLIO_IRQ_GROUND_COMMAND_SHIFTER]) begin
            // Clearing the command flag rearms the command shifter for the next word.
            next_dl[`DLIO_IDX_GROUND_COMMAND_SHIFTER] = '0;
            next_dl[`DLIO_IDX_GROUND_COMMAND_SHIFTER + 1] = '0;
        end
        if (rng_start) begin
            next_dl[`DLIO_IDX_RANGE] = 13'h0001;
            next_dl[`DLIO_IDX_RANGE + 1] = '0;
        end
        if (dl_load) begin
            next_dl[bus_idx] = pwdata[NW-1:0];
        end
    end

    // Loop storage, 24 words of 13 bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NREG; i++) begin
                dl[i] <= `DLIO_RST_WORD;
            end
        end else begin
            for (int i = 0; i < NREG; i++) begin
                dl[i] <= next_dl[i];
            end
        end
    end

    // Event flags; a new event always wins over its clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_s1 <= 1'b0;
            up_s2 <= 1'b0;
            up_val <= 1'b0;
            rd_s1 <= 1'b0;
            rd_s2 <= 1'b0;
            rt_pend <= 1'b0;
            out_pend <= 3'h0;
            irq_flags <= `DLIO_RST_IRQ;
            cp_interrupt <= 1'b0;
        end else begin
            up_s1 <= ground_command_shifter_bit;
            up_s2 <= up_s1;
            rd_s1 <= radar_bit;
            rd_s2 <= rd_s1;
            if (up_fresh) begin
                up_val <= up_s2;
            end
            rt_pend <= rt_event | (rt_pend & ~rt_done);
            out_pend <= {3{out_tick}} | (out_pend & ~out_done);
            irq_flags <= irq_set | (irq_flags & ~irq_clear);
            cp_interrupt <= |(irq_set | (irq_flags & ~irq_clear));
        end
    end

    // Range sequencer and 3.2 kcps output pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rng_active <= 1'b0;
            rng_pend <= 1'b0;
            rng_val <= 1'b0;
            radar_pulse <= 1'b0;
            accel_interrogate <= 1'b0;
            pulse_out <= '0;
        end else begin
            accel_interrogate <= out_tick;
            pulse_out <= next_pulse;
            radar_pulse <= out_tick && rng_active && !rng_stop;
            if (rng_start) begin
                rng_active <= 1'b1;
            end else if (rng_stop) begin
                rng_active <= 1'b0;
            end
            if (out_tick && rng_active && !rng_stop) begin
                rng_pend <= 1'b1;
                rng_val <= rd_s2;
            end else if (rng_done || rng_start) begin
                rng_pend <= 1'b0;
            end
        end
    end

    // APB slave: the answer waits for the addressed word to pass a B or C phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= DLIO_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            case (state)
                DLIO_IDLE: begin
                    if (bus_go) begin
                        state <= DLIO_ACK;
                        pready <= 1'b1;
                        pslverr <= bus_err;
                        prdata <= pwrite ? 32'h00000000 : bus_rdata;
                    end
                end
                DLIO_ACK: begin
                    state <= DLIO_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    state <= DLIO_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end
endmodule // dlio_counters
`default_nettype wire

// ### hw/dlio_map.svh
// Register offsets, field positions, reset values and timing figures of the delay-line counter block.
`ifndef DLIO_MAP_SVH
`define DLIO_MAP_SVH

`define DLIO_REG_COUNT 24
`define DLIO_WORD_BITS 13
`define DLIO_OFS_DL_BASE 12'h000
`define DLIO_OFS_DL_END 12'h060
`define DLIO_OFS_STATUS 12'h080
`define DLIO_OFS_IRQ 12'h084
`define DLIO_OFS_CTRL 12'h088

`define DLIO_ST_PARITY 0
`define DLIO_ST_PHASE_LO 1
`define DLIO_ST_RANGE_BUSY 4
`define DLIO_IRQ_GROUND_COMMAND_SHIFTER 0
`define DLIO_IRQ_TIMER1 1
`define DLIO_IRQ_TIMER2 2
`define DLIO_CTRL_RANGE_REQ 0

`define DLIO_RST_WORD 13'h0000
`define DLIO_RST_IRQ 3'h0

`define DLIO_IDX_ACC_CH4 18
`define DLIO_IDX_GROUND_COMMAND_SHIFTER 9
`define DLIO_IDX_RANGE 6
`define DLIO_IDX_REALTIME 12
`define DLIO_IDX_TIMER1 18
`define DLIO_IDX_OUT0 20
`define DLIO_MARKER_POS 16

`define DLIO_PCLK_KHZ 40000
`define DLIO_BIT_KHZ 512
`define DLIO_BIT_HZ 512000
`define DLIO_TICK_HZ 100
`define DLIO_OUT_HZ 3200
`define DLIO_BITS_PER_PHASE 14
`define DLIO_PHASES 6

`endif

// ### hw/dlio_pkg.sv
// Types shared by the delay-line counter block.
package dlio_pkg;
    typedef struct packed {
        logic [9:0] plus;
        logic [9:0] minus;
    } dlio_pulse_t;
    typedef struct packed {
        logic [2:0] plus;
        logic [2:0] minus;
    } dlio_out_t;
    typedef enum logic {
        DLIO_IDLE,
        DLIO_ACK
    } dlio_apb_state_t;
endpackage

// ### hw/dlio_pulse_latch.sv
// Pin synchroniser and edge latch that holds each pulse until the loop consumes it.
`timescale 1ns/1ps
`default_nettype none
module dlio_pulse_latch #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin,
    input wire logic [WIDTH-1:0] clear,
    output logic [WIDTH-1:0] held,
    output logic [WIDTH-1:0] fresh
);
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] prev;
    wire [WIDTH-1:0] rise = sync2 & ~prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
            held <= '0;
            fresh <= '0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            prev <= sync2;
            // A new edge in the clearing cycle is kept.
            held <= rise | (held & ~clear);
            fresh <= rise;
        end
    end
endmodule // dlio_pulse_latch
`default_nettype wire

// ### bench/dlio_counters_sva.sv
// Port checker for the delay-line counter block.
`timescale 1ns/1ps
`default_nettype none
`include "dlio_map.svh"
module dlio_counters_sva import dlio_pkg::*; #(
    parameter int BIT_NUM = 1,
    parameter int BIT_DEN = 2,
    parameter int TICKS_OUT = 100
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic accel_interrogate,
    input wire logic radar_pulse,
    input wire dlio_out_t pulse_out,
    input wire logic cp_interrupt
);
    localparam int LOOP_MAX = 84 * BIT_DEN / BIT_NUM + 8;
    localparam int OUT_PER = TICKS_OUT * BIT_DEN / BIT_NUM;
    int wait_cnt;
    int gap_cnt;
    logic seen_tick;
    wire loop_word = paddr < `DLIO_OFS_DL_END;
    wire ch4_word = loop_word && paddr >= 12'h048;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 0;
            gap_cnt <= 0;
            seen_tick <= 1'h0;
        end else begin
            wait_cnt <= (psel && penable && !pready) ? wait_cnt + 1 : 0;
            gap_cnt <= accel_interrogate ? 0 : gap_cnt + 1;
            seen_tick <= seen_tick | accel_interrogate;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access_start;
        psel && penable && !pready && wait_cnt == 0;
    endsequence
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_FAST_REG: assert property (s_access_start ##0 !loop_word |=> pready)
        else $error("register access not answered in one cycle");
    AST_LOOP_WAIT: assert property (wait_cnt <= LOOP_MAX)
        else $error("loop word not reached within one loop");
    AST_LOW_WRITE_REFUSED: assert property (pready && pwrite && loop_word && !ch4_word |-> pslverr)
        else $error("load into an input channel accepted");
    AST_CH4_WRITE_TAKEN: assert property (pready && pwrite && ch4_word |-> !pslverr)
        else $error("load into channel four refused");
    AST_WORD_WIDTH: assert property (pready && !pwrite && loop_word |-> prdata[31:13] == 19'h0)
        else $error("loop word wider than thirteen bits");
    AST_INTERROGATE_PERIOD: assert property (accel_interrogate && seen_tick |-> gap_cnt inside {[OUT_PER - 2:OUT_PER]})
        else $error("interrogation period wrong");
    AST_OUT_PULSE: assert property (|pulse_out |=> pulse_out == 6'h00)
        else $error("output pulse longer than one cycle");
    AST_IRQ_CLEAR: assert property (pready && pwrite && paddr == `DLIO_OFS_IRQ && pwdata[2:0] == 3'h7 |=> !cp_interrupt)
        else $error("interrupt stays after clearing all flags");
    AST_RADAR_SPACING: assert property (radar_pulse |=> !radar_pulse [*4])
        else $error("radar pulses too close");
endmodule // dlio_counters_sva
bind dlio_counters dlio_counters_sva #(.BIT_NUM(BIT_NUM), .BIT_DEN(BIT_DEN), .TICKS_OUT(TICKS_OUT)) i_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .accel_interrogate(accel_interrogate),
    .radar_pulse(radar_pulse), .pulse_out(pulse_out), .cp_interrupt(cp_interrupt));
`default_nettype wire

// ### bench/dlio_far_model.sv
// Sensor and actuator model that pulses the block's inputs and counts its output pulses.
`timescale 1ns/1ps
`default_nettype none
module dlio_far_model import dlio_pkg::*; (
    input wire logic pclk,
    input wire logic accel_interrogate,
    input wire logic radar_pulse,
    input wire dlio_out_t pulse_out,
    output wire dlio_pulse_t pulse_in,
    output wire logic radar_bit
);
    int plus_left [10];
    int minus_left [10];
    int width [10];
    logic sgn [10];
    int gap = 0;
    int out_plus [3];
    int out_minus [3];
    int radar_cnt = 0;
    logic [9:0] plus_pins = 10'h000;
    logic [9:0] minus_pins = 10'h000;
    assign pulse_in = {plus_pins, minus_pins};
    // The returned range bit alternates with each pulse, so a slipped shift shows in the result.
    assign radar_bit = radar_cnt[0];
    always @(posedge pclk) begin
        gap <= (gap >= 210) ? 0 : gap + 1;
        radar_cnt <= radar_cnt + int'(radar_pulse);
        for (int k = 0; k < 3; k++) begin
            out_plus[k] += int'(pulse_out.plus[k]);
            out_minus[k] += int'(pulse_out.minus[k]);
        end
        for (int j = 0; j < 10; j++) begin
            if (width[j] > 0) begin
                width[j]--;
            end else if ((j < 3 ? accel_interrogate : gap == 0) && plus_left[j] + minus_left[j] > 0) begin
                width[j] = 4;
                sgn[j] = plus_left[j] > 0;
                if (sgn[j]) plus_left[j]--;
                else minus_left[j]--;
            end
            plus_pins[j] <= width[j] > 1 && sgn[j];
            minus_pins[j] <= width[j] > 1 && !sgn[j];
        end
    end
endmodule // dlio_far_model
`default_nettype wire

// ### bench/test_delay_line_io_counters.sv
// Self-checking bench for the delay-line counter block.
`timescale 1ns/1ps
`default_nettype none
`include "dlio_map.svh"
module test_delay_line_io_counters import dlio_pkg::*; ;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ground_command_shifter_bit = 1'h0;
    logic ground_command_shifter_strobe = 1'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, accel_interrogate, radar_pulse, cp_interrupt, radar_bit;
    dlio_out_t pulse_out;
    wire dlio_pulse_t pulse_in;
    int miscompares = 0;
    int total_checks = 0;
    always #12.5 pclk = ~pclk;
    dlio_counters #(.BIT_NUM(1), .BIT_DEN(2), .TICKS_100CPS(100), .TICKS_OUT(100)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
        .ground_command_shifter_bit(ground_command_shifter_bit), .ground_command_shifter_strobe(ground_command_shifter_strobe), .radar_bit(radar_bit),
        .accel_interrogate(accel_interrogate), .radar_pulse(radar_pulse), .pulse_out(pulse_out),
        .cp_interrupt(cp_interrupt));
    dlio_far_model i_far (.pclk(pclk), .accel_interrogate(accel_interrogate), .radar_pulse(radar_pulse),
        .pulse_out(pulse_out), .pulse_in(pulse_in), .radar_bit(radar_bit));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdw(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'h0, a, 32'h0);
        chk(what, rd, exp);
    endtask
    task automatic t_refuse();
        rdw(`DLIO_OFS_IRQ, 32'h0, "irq at reset");
        apb(1'h1, 12'h000, 32'h5);
        chk("input load error", 32'(err), 32'h1);
        rdw(12'h000, 32'h0, "input word kept");
        apb(1'h1, 12'h0FC, 32'h1);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'h1, 12'h05C, 32'hABC);
        chk("spare load", 32'(err), 32'h0);
        repeat (400) @(posedge pclk);
        rdw(12'h05C, 32'hABC, "spare recirculates");
    endtask
    task automatic t_phase();
        logic [2:0] p;
        for (int k = 0; k < 24; k += 5) begin
            apb(1'h0, 12'(4 * k), 32'h0);
            apb(1'h0, `DLIO_OFS_STATUS, 32'h0);
            p = rd[3:1];
            chk("slot phase", 32'(p == k % 6 || p == (k + 1) % 6 || p == (k + 4) % 6 || p == (k + 5) % 6), 32'h1);
            chk("odd flag", 32'(rd[0]), 32'(p < 3));
            chk("phase range", 32'(p < 6), 32'h1);
        end
    endtask
    task automatic t_accum();
        int w;
        for (int j = 0; j < 10; j++) begin
            i_far.plus_left[j] = j % 3 + 1;
            i_far.minus_left[j] = j == 9 ? 3 : 1;
        end
        repeat (1500) @(posedge pclk);
        for (int j = 0; j < 10; j++) begin
            w = j < 6 ? j : (j == 6 ? 8 : (j == 7 ? 11 : j + 6));
            rdw(12'(4 * w), 32'((j % 3 - (j == 9 ? 2 : 0)) & 13'h1FFF), "accumulator");
        end
    endtask
    task automatic t_realtime();
        longint t0;
        logic [31:0] v0;
        int n;
        apb(1'h0, 12'h030, 32'h0);
        t0 = $time;
        v0 = rd;
        repeat (800) @(posedge pclk);
        apb(1'h0, 12'h030, 32'h0);
        n = int'(($time - t0) / 5000);
        chk("real time step", 32'(rd - v0 + 2 >= n && rd - v0 <= n + 1), 32'h1);
    endtask
    task automatic t_timers();
        int n;
        for (int t = 0; t < 2; t++) begin
            apb(1'h1, 12'(12'h048 + 4 * t), 32'h1FFD);
            n = 0;
            while (cp_interrupt !== 1'h1 && n < 2000) begin
                @(posedge pclk);
                n++;
            end
            chk("timer span", 32'(n >= 300 && n <= 700), 32'h1);
            rdw(`DLIO_OFS_IRQ, 32'(2 << t), "timer flag");
            apb(1'h1, `DLIO_OFS_IRQ, 32'(2 << t));
            rdw(`DLIO_OFS_IRQ, 32'h0, "flag cleared");
            chk("irq line low", 32'(cp_interrupt), 32'h0);
        end
    endtask
    task automatic t_outputs();
        apb(1'h1, 12'h050, 32'h3);
        apb(1'h1, 12'h054, 32'h1FFE);
        apb(1'h1, 12'h058, 32'h1);
        repeat (1000) @(posedge pclk);
        chk("optics plus", 32'(i_far.out_plus[0]), 32'h3);
        chk("radar minus", 32'(i_far.out_minus[1]), 32'h2);
        chk("angle plus", 32'(i_far.out_plus[2]), 32'h1);
        chk("wrong sign", 32'(i_far.out_minus[0] + i_far.out_plus[1] + i_far.out_minus[2]), 32'h0);
        rdw(12'h054, 32'h0, "output drained");
    endtask
    task automatic t_ground_command_shifter();
        logic [15:0] data;
        data = 16'hA5C3;
        for (int i = 16; i >= 0; i--) begin
            if (i == 0) chk("early ground_command_shifter irq", 32'(cp_interrupt), 32'h0);
            ground_command_shifter_bit <= i == 16 ? 1'h1 : data[i];
            @(posedge pclk);
            ground_command_shifter_strobe <= 1'h1;
            repeat (3) @(posedge pclk);
            ground_command_shifter_strobe <= 1'h0;
            repeat (400) @(posedge pclk);
        end
        rdw(`DLIO_OFS_IRQ, 32'h1, "ground_command_shifter flag");
        rdw(12'h024, 32'(data[12:0]), "ground_command_shifter low");
        rdw(12'h028, 32'({1'h1, data[15:13]}), "ground_command_shifter high");
        apb(1'h1, `DLIO_OFS_IRQ, 32'h7);
    endtask
    task automatic t_range();
        apb(1'h1, `DLIO_OFS_CTRL, 32'h1);
        repeat (4500) @(posedge pclk);
        chk("radar pulses", 32'(i_far.radar_cnt >= 16 && i_far.radar_cnt <= 17), 32'h1);
        rdw(12'h018, 32'h1555, "range low");
        rdw(12'h01C, 32'h000A, "range high");
        rdw(`DLIO_OFS_CTRL, 32'h0, "range done");
    endtask
    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        t_refuse();
        t_phase();
        t_accum();
        t_realtime();
        t_timers();
        t_outputs();
        t_ground_command_shifter();
        t_range();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge pclk);
        miscompares++;
        give_verdict();
    end
endmodule // test_delay_line_io_counters
`default_nettype wire
